// ---- hdl/sgdp_defs.vh ----
// Constants for the system glue, decode and parity block
`ifndef SGDP_DEFS_VH
`define SGDP_DEFS_VH

// Two-bit range select codes
`define SGDP_RANGE_NONE      2'h0
`define SGDP_RANGE_IO_VRAM   2'h1
`define SGDP_RANGE_VROM      2'h2
`define SGDP_RANGE_CHAN_LOW  2'h3

// Memory map, 24-bit byte addresses
`define SGDP_ONE_MEG         24'h10_0000
`define SGDP_RAM_TOP         24'h0A_0000
`define SGDP_VRAM_BASE       24'h0A_0000
`define SGDP_VRAM_TOP        24'h0C_0000
`define SGDP_VROM_BASE       24'h0C_0000
`define SGDP_VROM_TOP        24'h0C_8000
`define SGDP_BIOS_BASE       24'h0F_0000

// I/O addresses
`define SGDP_IO_FPU_BUSY     16'h00F8
`define SGDP_IO_FPU_BASE     16'h00F8
`define SGDP_IO_FPU_LAST     16'h00FF
`define SGDP_IO_DISK2_A      16'h03F6
`define SGDP_IO_DISK2_B      16'h03F7

// Speed codes on the clock select output
`define SGDP_SPEED_8MHZ      2'h0

// Reset stretch after power becomes stable
`define SGDP_CLK_MHZ         25
`define SGDP_RST_HOLD_NS     1000
`define SGDP_RST_HOLD_CYC    ((`SGDP_RST_HOLD_NS * `SGDP_CLK_MHZ + 999) / 1000)
`define SGDP_RST_CNT_W       8

// Width of the synchroniser bank
`define SGDP_SYNC_W          62

`endif

// ---- hdl/sgdp_top.v ----
// System glue: range decode, data-path control, parity, NMI, speed and reset
//
// Notes on behaviour
// - Range code encodes none, IO/video RAM, video ROM, channel memory
// - Channel path enabled for channel memory and acknowledge
// - Parity enable low while onboard RAM accessed
// - ROM/RAM read copies coprocessor busy at F8H
// - SX opcode fetch turns ROM/RAM read into input
// - One parity bit per byte on writes
// - Check both parity bits at onboard RAM read end
// - NMI on parity error or channel check
// - Low range line carries turbo during refresh
// - Second disk select low at 3F6H/3F7H if installed
// - Turbo high forces 8 MHz, else programmed speed
// - Cache flush on expanded-memory mapper update
// - Operand request follows coprocessor request
// - Refresh request tells arbiter DRAM needs refresh
// - Channel memory commands only below one megabyte
// - Reset active high, synchronous, from power good
`include "sgdp_defs.vh"
`default_nettype none

module sgdp_top #(
    parameter RST_HOLD_CYC = `SGDP_RST_HOLD_CYC  // Reset stretch after power is stable
) (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire [23:0] cpu_addr,
    input  wire        mem_cycle,
    input  wire        write_cycle,
    input  wire        cycle_active,
    input  wire        int_ack_n,
    input  wire        fpu_opcode_fetch,
    input  wire        cpu_is_sx,
    input  wire        refresh_active_n,
    input  wire        speed_select_n,
    input  wire        fpu_busy_n,
    input  wire        fpu_operand_request,
    input  wire        channel_check_n,
    input  wire [15:0] mem_data,
    input  wire [1:0]  parity_in,
    input  wire        parity_clear,
    input  wire        ems_map_write,
    input  wire        refresh_tick,
    input  wire        power_stable,
    input  wire [1:0]  speed_program,
    input  wire        disk_two_installed,
    input  wire        data_buffer_enable_n,
    input  wire        rom_ram_read_i,
    output reg  [1:0]  range_code,
    output reg         channel_path_enable_n,
    output reg         parity_enable_out_n,
    output reg         rom_ram_read_o,
    output reg         rom_ram_read_oe,
    output reg         fpu_busy_seen_n,
    output reg  [1:0]  parity_out,
    output reg         parity_out_oe,
    output reg         parity_error,
    output reg         nmi,
    output reg         disk_select_two_n,
    output reg  [1:0]  cpu_speed_code,
    output reg         cache_flush,
    output reg         cpu_operand_request,
    output reg         refresh_request,
    output reg         channel_low_mem_read_n,
    output reg         channel_low_mem_write_n,
    output reg         system_reset,
    output reg         transceiver_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    wire [`SGDP_SYNC_W-1:0] async_in;   // All pin inputs, packed
    reg  [`SGDP_SYNC_W-1:0] meta_r;     // First stage, read only by second
    reg  [`SGDP_SYNC_W-1:0] sync_r;     // Second stage, safe to decode

    // Order matches the unpack
    assign async_in = {cpu_addr, mem_cycle, write_cycle, cycle_active, int_ack_n,
                       fpu_opcode_fetch, cpu_is_sx, refresh_active_n, speed_select_n,
                       fpu_busy_n, fpu_operand_request, channel_check_n, mem_data,
                       parity_in, parity_clear, ems_map_write, refresh_tick,
                       power_stable, speed_program, disk_two_installed,
                       data_buffer_enable_n, rom_ram_read_i};

    // Two flops per bit; no reset, so pins are still sampled while under reset
    genvar gi;
    generate
        for (gi = 0; gi < `SGDP_SYNC_W; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk) begin
                meta_r[gi] <= async_in[gi];
                sync_r[gi] <= meta_r[gi];
            end
        end
    endgenerate

    wire [23:0] s_addr;       // Synchronised CPU address
    wire        s_mem;        // Memory cycle
    wire        s_wr;         // Write cycle
    wire        s_cyc;        // Cycle in progress
    wire        s_inta_n;     // Interrupt acknowledge
    wire        s_opfetch;    // Coprocessor opcode fetch
    wire        s_sx;         // SX-class CPU strap
    wire        s_ref_n;      // Refresh period
    wire        s_turbo_n;    // Turbo switch
    wire        s_busy_n;     // Coprocessor busy
    wire        s_preq;       // Coprocessor operand request
    wire        s_chk_n;      // Channel check
    wire [15:0] s_data;       // Memory data
    wire [1:0]  s_par;        // Parity bits read back
    wire        s_pclr;       // Parity error clear
    wire        s_ems;        // Mapper write strobe
    wire        s_rtick;      // Refresh timer tick
    wire        s_pwr;        // Power good
    wire [1:0]  s_spd;        // Programmed speed
    wire        s_disk2;      // Second drive fitted
    wire        s_den_n;      // Data buffer enable
    wire        s_rmrd;       // ROM/RAM read line as input

    // Same order as packed
    assign {s_addr, s_mem, s_wr, s_cyc, s_inta_n, s_opfetch, s_sx, s_ref_n, s_turbo_n,
            s_busy_n, s_preq, s_chk_n, s_data, s_par, s_pclr, s_ems, s_rtick, s_pwr,
            s_spd, s_disk2, s_den_n, s_rmrd} = sync_r;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire        io_cyc;       // Active I/O cycle
    wire        mem_act;      // Active memory cycle
    wire        below_1m;     // Address within first megabyte
    wire        in_ram;       // Onboard system RAM window
    wire        in_bios;      // Onboard BIOS ROM window
    wire        in_vram;      // Onboard video RAM window
    wire        in_vrom;      // Onboard video ROM window
    wire        onboard;      // Onboard system RAM or BIOS ROM memory access
    wire        chan_low;     // Channel memory below one megabyte
    wire        io_low;       // I/O address with bits 15..10 clear
    wire        io_fpu;       // Coprocessor I/O space
    wire        io_busy;      // Busy readback port
    wire        io_disk2;     // Second disk ports

    // Acknowledge: not I/O, not memory
    assign io_cyc   = s_cyc & ~s_mem & s_inta_n;
    assign mem_act  = s_cyc & s_mem & s_inta_n;
    assign below_1m = s_addr < `SGDP_ONE_MEG;
    assign in_ram   = s_addr < `SGDP_RAM_TOP;
    assign in_bios  = below_1m & (s_addr >= `SGDP_BIOS_BASE);
    assign in_vram  = (s_addr >= `SGDP_VRAM_BASE) & (s_addr < `SGDP_VRAM_TOP);
    assign in_vrom  = (s_addr >= `SGDP_VROM_BASE) & (s_addr < `SGDP_VROM_TOP);
    assign onboard  = mem_act & (in_ram | in_bios);
    assign chan_low = mem_act & below_1m & ~in_ram & ~in_bios & ~in_vram & ~in_vrom;
    assign io_low   = io_cyc & (s_addr[15:10] == 6'h00);
    // Coprocessor ports off channel
    assign io_fpu   = io_cyc & (s_addr[15:0] >= `SGDP_IO_FPU_BASE)
                             & (s_addr[15:0] <= `SGDP_IO_FPU_LAST);
    assign io_busy  = io_cyc & (s_addr[15:0] == `SGDP_IO_FPU_BUSY);
    assign io_disk2 = io_cyc & ((s_addr[15:0] == `SGDP_IO_DISK2_A)
                              | (s_addr[15:0] == `SGDP_IO_DISK2_B));

    // Range code; the low line is swapped for turbo state while refreshing
    reg [1:0] range_nxt;
    always @* begin
        if (io_low | (mem_act & in_vram)) begin
            range_nxt = `SGDP_RANGE_IO_VRAM;
        end else if (mem_act & in_vrom) begin
            range_nxt = `SGDP_RANGE_VROM;
        end else if (chan_low) begin
            range_nxt = `SGDP_RANGE_CHAN_LOW;
        end else begin
            range_nxt = `SGDP_RANGE_NONE;
        end
        if (!s_ref_n) begin
            range_nxt[0] = s_turbo_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parity helpers

    wire [1:0] par_calc;      // Odd parity per byte, bit 0 for even byte
    wire       par_bad;       // Read-back mismatch on either byte
    reg        cyc_d_r;       // Cycle flag one clock late
    reg        rd_onb_r;      // Onboard RAM read in progress
    wire       rd_end;        // First clock after an onboard RAM read ends

    // Odd: a zero byte still checks
    assign par_calc = {~^s_data[15:8], ~^s_data[7:0]};
    assign par_bad  = s_par != par_calc;
    assign rd_end   = cyc_d_r & ~s_cyc & rd_onb_r;

    // Track onboard RAM reads so the check happens as the cycle closes
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cyc_d_r  <= 1'b0;
            rd_onb_r <= 1'b0;
        end else begin
            cyc_d_r  <= s_cyc;
            rd_onb_r <= s_cyc ? (onboard & ~s_wr & in_ram) : 1'b0;
        end
    end

    // Data captured while the onboard read runs; checked at its end
    reg par_bad_r;            // Mismatch seen on the last sampled read data
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            par_bad_r <= 1'b0;
        end else if (rd_onb_r & s_cyc) begin
            par_bad_r <= par_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge detectors and strap capture

    reg ems_d_r;              // Mapper strobe one clock late
    reg rtick_d_r;            // Refresh tick one clock late
    reg sx_r;                 // SX strap one clock late
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ems_d_r   <= 1'b0;
            rtick_d_r <= 1'b0;
            sx_r      <= 1'b0;
        end else begin
            ems_d_r   <= s_ems;
            rtick_d_r <= s_rtick;
            sx_r      <= s_sx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset generation: hold reset until power has been good for a while

    reg [`SGDP_RST_CNT_W-1:0] rst_cnt_r;  // Cycles of stable power seen
    wire rst_done;
    // Counter stops at the hold
    assign rst_done = rst_cnt_r >= RST_HOLD_CYC[`SGDP_RST_CNT_W-1:0];

    always @(posedge sys_clk) begin
        if (sys_rst | ~s_pwr) begin
            rst_cnt_r    <= {`SGDP_RST_CNT_W{1'b0}};
            system_reset <= 1'b1;
        end else begin
            if (!rst_done) begin
                rst_cnt_r <= rst_cnt_r + 1'b1;
            end
            system_reset <= ~rst_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            // Idle levels
            range_code              <= `SGDP_RANGE_NONE;
            channel_path_enable_n   <= 1'b1;
            parity_enable_out_n     <= 1'b1;
            rom_ram_read_o          <= 1'b1;
            rom_ram_read_oe         <= 1'b0;
            fpu_busy_seen_n         <= 1'b1;
            parity_out              <= 2'h0;
            parity_out_oe           <= 1'b0;
            parity_error            <= 1'b0;
            nmi                     <= 1'b0;
            disk_select_two_n       <= 1'b1;
            cpu_speed_code          <= `SGDP_SPEED_8MHZ;
            cache_flush             <= 1'b0;
            cpu_operand_request     <= 1'b0;
            refresh_request         <= 1'b0;
            channel_low_mem_read_n  <= 1'b1;
            channel_low_mem_write_n <= 1'b1;
            transceiver_enable      <= 1'b0;
        end else begin
            // Swap already applied
            range_code <= range_nxt;

            // Path open for channel memory, non-coprocessor I/O, acknowledge
            channel_path_enable_n <= ~((mem_act & ~onboard) | (io_cyc & ~io_fpu)
                                       | (s_cyc & ~s_inta_n));

            // Onboard RAM only
            parity_enable_out_n <= ~(onboard & in_ram);

            // ROM/RAM read line: input on SX opcode fetch, busy copy at F8H
            if (sx_r & s_opfetch) begin
                rom_ram_read_oe <= 1'b0;
                fpu_busy_seen_n <= s_rmrd;
            end else if (io_busy) begin
                rom_ram_read_oe <= 1'b1;
                rom_ram_read_o  <= s_busy_n;
            end else begin
                rom_ram_read_oe <= 1'b1;
                rom_ram_read_o  <= ~(onboard & ~s_wr);
            end

            // Parity driven on every memory write
            parity_out    <= par_calc;
            parity_out_oe <= mem_act & s_wr;

            // Sticky error; a new error wins over a clear in the same clock
            if (rd_end & par_bad_r) begin
                parity_error <= 1'b1;
            end else if (s_pclr) begin
                parity_error <= 1'b0;
            end

            // Level, not a pulse
            nmi <= parity_error | (rd_end & par_bad_r) | ~s_chk_n;

            // Gated by strap
            disk_select_two_n <= ~(io_disk2 & s_disk2);

            // Turbo switch high means the slow fixed speed
            cpu_speed_code <= s_turbo_n ? `SGDP_SPEED_8MHZ : s_spd;

            // Rising edge only
            cache_flush <= s_ems & ~ems_d_r;

            // Plain forward
            cpu_operand_request <= s_preq;

            // Request set by timer tick, dropped once refresh starts; set wins
            if (s_rtick & ~rtick_d_r) begin
                refresh_request <= 1'b1;
            end else if (!s_ref_n) begin
                refresh_request <= 1'b0;
            end

            channel_low_mem_read_n  <= ~(chan_low & ~s_wr);
            channel_low_mem_write_n <= ~(chan_low & s_wr);

            // Pin is active low
            transceiver_enable <= ~s_den_n;
        end
    end

endmodule

`default_nettype wire

// ---- verif/sgdp_checker.sv ----
// Checker: timed relations between the glue block's inputs and outputs
`default_nettype none
module sgdp_checker (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [23:0] cpu_addr,
    input wire logic        mem_cycle,
    input wire logic        cycle_active,
    input wire logic        int_ack_n,
    input wire logic        refresh_active_n,
    input wire logic        speed_select_n,
    input wire logic [1:0]  speed_program,
    input wire logic        fpu_operand_request,
    input wire logic        channel_check_n,
    input wire logic        ems_map_write,
    input wire logic        disk_two_installed,
    input wire logic [1:0]  range_code,
    input wire logic        channel_path_enable_n,
    input wire logic        parity_enable_out_n,
    input wire logic        nmi,
    input wire logic        disk_select_two_n,
    input wire logic [1:0]  cpu_speed_code,
    input wire logic        cache_flush,
    input wire logic        cpu_operand_request
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    // Edges since reset release; $past looks back three, so wait that out
    logic [2:0] up_cnt_r;
    always @(posedge sys_clk) begin
        if (sys_rst)
            up_cnt_r <= 3'h0;
        else if (up_cnt_r != 3'h5)
            up_cnt_r <= up_cnt_r + 3'h1;
    end
    wire live   = (up_cnt_r == 3'h5);
    // Decoded causes, looked at three edges later
    wire cpu_c  = cycle_active && int_ack_n; // No acknowledge
    wire vrom_c = cpu_c && mem_cycle && refresh_active_n && cpu_addr[23:15] == 9'h018;
    wire ram_c  = cpu_c && mem_cycle && cpu_addr < 24'h0A_0000;
    wire ack_c  = cycle_active && !int_ack_n;
    wire disk_c = cpu_c && !mem_cycle && disk_two_installed && cpu_addr[15:1] == 15'h01FB;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // A flush is exactly one clock wide
    sequence s_one_pulse;
        cache_flush ##1 !cache_flush;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_range_vrom: assert property (live && $past(vrom_c, 3) |-> range_code == 2'h2)
        else $error("range code not video ROM");
    a_parity_enable: assert property (live && $past(ram_c, 3) |-> !parity_enable_out_n)
        else $error("parity enable not low for onboard RAM");
    a_path_ack: assert property (live && $past(ack_c, 3) |-> !channel_path_enable_n)
        else $error("channel path not enabled in acknowledge");
    a_disk_two: assert property (live && $past(disk_c, 3) |-> !disk_select_two_n)
        else $error("second disk select not low");
    a_turbo_refresh: assert property (live && !$past(refresh_active_n, 3) |->
        range_code[0] == $past(speed_select_n, 3)) else $error("low range line not turbo");
    a_speed_force: assert property (live |-> cpu_speed_code ==
        ($past(speed_select_n, 3) ? 2'h0 : $past(speed_program, 3))) else $error("speed code");
    a_operand_req: assert property (live |-> cpu_operand_request == $past(fpu_operand_request, 3))
        else $error("operand request not forwarded");
    a_nmi_check: assert property (live && !$past(channel_check_n, 3) |-> nmi)
        else $error("nmi missing on channel check");
    a_flush_pulse: assert property (live && $rose(ems_map_write) |-> ##[3:4] s_one_pulse)
        else $error("flush pulse missing or too long");
endmodule

bind sgdp_top sgdp_checker i_chk (
    .sys_clk, .sys_rst, .cpu_addr, .mem_cycle, .cycle_active, .int_ack_n, .refresh_active_n,
    .speed_select_n, .speed_program, .fpu_operand_request, .channel_check_n, .ems_map_write,
    .disk_two_installed, .range_code, .channel_path_enable_n, .parity_enable_out_n, .nmi,
    .disk_select_two_n, .cpu_speed_code, .cache_flush, .cpu_operand_request);
`default_nettype wire

// ---- verif/sgdp_fpu_model.sv ----
// Coprocessor stand-in: busy, operand request and the shared read line
`default_nettype none
module sgdp_fpu_model (
    input  wire logic sys_clk,
    input  wire logic busy_cmd,
    input  wire logic req_cmd,
    input  wire logic rrd_o,
    input  wire logic rrd_oe,
    output var  logic fpu_busy_n,
    output var  logic fpu_operand_request,
    output wire logic rrd_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle at time zero: not busy, no request
    initial fpu_busy_n = 1'h1;
    initial fpu_operand_request = 1'h0;
    // Lines move just after an edge and hold a full cycle
    always @(posedge sys_clk) begin
        fpu_busy_n <= !busy_cmd;
        fpu_operand_request <= req_cmd;
    end
    // Block drives when enabled, else busy shows through
    assign rrd_line = rrd_oe ? rrd_o : fpu_busy_n;
endmodule
`default_nettype wire

// ---- verif/tb_system_glue_decode_parity.sv ----
// Self-checking bench for the glue, decode and parity block
`default_nettype none
module tb_system_glue_decode_parity;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 4; // Short reset stretch keeps the run brief
    logic        sys_clk = 1'h0, sys_rst = 1'h1, power_stable = 1'h1;
    logic [23:0] cpu_addr = 24'h00_0000;
    logic [15:0] mem_data = 16'h0000;
    logic [1:0]  parity_in = 2'h0, speed_program = 2'h0;
    logic        mem_cycle = 1'h0, write_cycle = 1'h0, cycle_active = 1'h0;
    logic        fpu_opcode_fetch = 1'h0, cpu_is_sx = 1'h0, parity_clear = 1'h0;
    logic        ems_map_write = 1'h0, refresh_tick = 1'h0, disk_two_installed = 1'h1;
    logic        busy_cmd = 1'h0, req_cmd = 1'h0, int_ack_n = 1'h1, refresh_active_n = 1'h1;
    logic        speed_select_n = 1'h1, channel_check_n = 1'h1, data_buffer_enable_n = 1'h1;
    logic [1:0]  range_code, parity_out, cpu_speed_code;
    logic        channel_path_enable_n, parity_enable_out_n, rom_ram_read_o, rom_ram_read_oe;
    logic        fpu_busy_seen_n, parity_out_oe, parity_error, nmi, disk_select_two_n;
    logic        cache_flush, cpu_operand_request, refresh_request, channel_low_mem_read_n;
    logic        channel_low_mem_write_n, system_reset, transceiver_enable;
    logic        fpu_busy_n, fpu_operand_request;
    wire         rrd_line;
    int          err_total = 0, tests_run = 0, cyc_cnt = 0;

    sgdp_top #(.RST_HOLD_CYC(HOLD)) i_dut (
        .sys_clk, .sys_rst, .cpu_addr, .mem_cycle, .write_cycle, .cycle_active, .int_ack_n,
        .fpu_opcode_fetch, .cpu_is_sx, .refresh_active_n, .speed_select_n, .fpu_busy_n,
        .fpu_operand_request, .channel_check_n, .mem_data, .parity_in, .parity_clear,
        .ems_map_write, .refresh_tick, .power_stable, .speed_program, .disk_two_installed,
        .data_buffer_enable_n, .rom_ram_read_i(rrd_line), .range_code, .channel_path_enable_n,
        .parity_enable_out_n, .rom_ram_read_o, .rom_ram_read_oe, .fpu_busy_seen_n, .parity_out,
        .parity_out_oe, .parity_error, .nmi, .disk_select_two_n, .cpu_speed_code, .cache_flush,
        .cpu_operand_request, .refresh_request, .channel_low_mem_read_n,
        .channel_low_mem_write_n, .system_reset, .transceiver_enable);
    sgdp_fpu_model i_fpu (.sys_clk, .busy_cmd, .req_cmd, .rrd_o(rom_ram_read_o),
        .rrd_oe(rom_ram_read_oe), .fpu_busy_n, .fpu_operand_request, .rrd_line);

    always #20 sys_clk = ~sys_clk;
    // A hung run counts as a mismatch and closes
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 2000) begin
            err_total++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Pass n edges, then step off the edge so outputs have settled
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One CPU cycle; the decode answers three edges after inputs move
    task automatic bus(input logic [23:0] a, input logic m, input logic w);
        @(posedge sys_clk);
        cpu_addr <= a;
        mem_cycle <= m;
        write_cycle <= w;
        cycle_active <= 1'h1;
        ticks(3);
    endtask
    // Read cycle, judged as {range code, path enable, parity enable}
    task automatic dec(input logic [23:0] a, input logic m, input logic [3:0] exp);
        bus(a, m, 1'h0);
        chk({range_code, channel_path_enable_n, parity_enable_out_n}, exp);
    endtask
    task automatic set_ack(input logic v);
        @(posedge sys_clk);
        int_ack_n <= v;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_decode();
        dec(24'h00_0060, 1'h0, 4'h5);
        dec(24'h0A_0000, 1'h1, 4'h5);
        dec(24'h0C_0000, 1'h1, 4'h9);
        dec(24'h0D_0000, 1'h1, 4'hD);
        chk(channel_low_mem_read_n, 1'h0);
        dec(24'h01_0000, 1'h1, 4'h2);
        dec(24'h0F_0000, 1'h1, 4'h3);
        dec(24'h20_0000, 1'h1, 4'h1);
        chk(channel_low_mem_read_n, 1'h1);
        dec(24'h00_0400, 1'h0, 4'h1);
        dec(24'h00_00F8, 1'h0, 4'h7);
        set_ack(1'h0);
        dec(24'h00_00F8, 1'h0, 4'h1);
        set_ack(1'h1);
        dec(24'h00_03F6, 1'h0, 4'h5);
        chk(disk_select_two_n, 1'h0);
        dec(24'h00_03F7, 1'h0, 4'h5);
        chk(disk_select_two_n, 1'h0);
        dec(24'h00_03F5, 1'h0, 4'h5);
        chk(disk_select_two_n, 1'h1);
        @(posedge sys_clk);
        disk_two_installed <= 1'h0;
        dec(24'h00_03F7, 1'h0, 4'h5);
        chk(disk_select_two_n, 1'h1);
        @(posedge sys_clk);
        disk_two_installed <= 1'h1;
    endtask
    // Onboard read, then end the cycle so parity is judged
    task automatic rd_end(input logic [1:0] par);
        @(posedge sys_clk);
        parity_in <= par;
        mem_data <= 16'h0301;
        bus(24'h01_0000, 1'h1, 1'h0);
        chk(parity_error, 1'h0);
        @(posedge sys_clk);
        cycle_active <= 1'h0;
        ticks(4);
    endtask
    task automatic t_parity();
        bus(24'h01_0000, 1'h1, 1'h1);
        chk({parity_out_oe, parity_out}, 3'h7);
        @(posedge sys_clk);
        mem_data <= 16'h7F00;
        ticks(3);
        chk({parity_out_oe, parity_out}, 3'h5);
        bus(24'h0D_0000, 1'h1, 1'h1);
        chk({channel_low_mem_write_n, channel_low_mem_read_n}, 2'h1);
        rd_end(2'h1);
        chk({parity_error, nmi}, 2'h3);
        ticks(20);
        chk({parity_error, nmi}, 2'h3);
        @(posedge sys_clk);
        parity_clear <= 1'h1;
        @(posedge sys_clk);
        parity_clear <= 1'h0;
        ticks(4);
        chk({parity_error, nmi}, 2'h0);
        rd_end(2'h2);
        chk({parity_error, nmi}, 2'h0);
    endtask
    task automatic t_misc();
        @(posedge sys_clk);
        channel_check_n <= 1'h0;
        speed_program <= 2'h2;
        ticks(3);
        chk({nmi, cpu_speed_code}, 3'h4);
        @(posedge sys_clk);
        channel_check_n <= 1'h1;
        speed_select_n <= 1'h0;
        refresh_tick <= 1'h1;
        data_buffer_enable_n <= 1'h0;
        ticks(3);
        chk({nmi, cpu_speed_code, refresh_request, transceiver_enable}, 5'h0B);
        @(posedge sys_clk);
        refresh_active_n <= 1'h0;
        ticks(3);
        chk({range_code[0], refresh_request}, 2'h0);
        @(posedge sys_clk);
        speed_select_n <= 1'h1;
        data_buffer_enable_n <= 1'h1;
        ticks(3);
        chk({range_code[0], transceiver_enable}, 2'h2);
        @(posedge sys_clk);
        refresh_active_n <= 1'h1;
        refresh_tick <= 1'h0;
    endtask
    task automatic t_fpu();
        @(posedge sys_clk);
        req_cmd <= 1'h1;
        busy_cmd <= 1'h1;
        bus(24'h00_00F8, 1'h0, 1'h0);
        chk({cpu_operand_request, rom_ram_read_oe, rom_ram_read_o}, 3'h6);
        @(posedge sys_clk);
        req_cmd <= 1'h0;
        busy_cmd <= 1'h0;
        ticks(4);
        chk({cpu_operand_request, rom_ram_read_oe, rom_ram_read_o}, 3'h3);
        @(posedge sys_clk);
        cpu_is_sx <= 1'h1;
        fpu_opcode_fetch <= 1'h1;
        busy_cmd <= 1'h1;
        ticks(7);
        chk({rom_ram_read_oe, fpu_busy_seen_n}, 2'h0);
        @(posedge sys_clk);
        busy_cmd <= 1'h0;
        ticks(4);
        chk({rom_ram_read_oe, fpu_busy_seen_n}, 2'h1);
        @(posedge sys_clk);
        cpu_is_sx <= 1'h0;
        fpu_opcode_fetch <= 1'h0;
    endtask
    // Mapper write held high must still give a single flush
    task automatic t_flush();
        logic [3:0] n;
        n = 4'h0;
        @(posedge sys_clk);
        ems_map_write <= 1'h1;
        repeat (8) begin
            ticks(1);
            n = n + {3'h0, cache_flush};
        end
        chk(n, 4'h1);
        @(posedge sys_clk);
        ems_map_write <= 1'h0;
    endtask
    task automatic t_power();
        @(posedge sys_clk);
        power_stable <= 1'h0;
        ticks(3);
        chk(system_reset, 1'h1);
        @(posedge sys_clk);
        power_stable <= 1'h1;
        ticks(HOLD + 2);
        chk(system_reset, 1'h1);
        ticks(5);
        chk(system_reset, 1'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ticks(15);
        chk({system_reset, nmi, parity_error, range_code}, 5'h10);
        @(posedge sys_clk);
        sys_rst <= 1'h0;
        ticks(HOLD + 10);
        chk(system_reset, 1'h0);
        t_decode();
        t_parity();
        t_misc();
        t_fpu();
        t_flush();
        t_power();
        close_out();
    end
endmodule
`default_nettype wire
